// File: src/iopb_pkg.sv
// Shared constants and carrier types for the I/O processor bus bridge
package iopb_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] REG_CMD     = 8'h00;  // Direct command launch
    localparam logic [7:0] REG_DIRECT  = 8'h04;  // Direct out / direct in
    localparam logic [7:0] REG_IRQDEV  = 8'h08;  // Interrupt device latch
    localparam logic [7:0] REG_MEMCTL  = 8'h0C;  // Memory operation launch
    localparam logic [7:0] REG_MEMDATA = 8'h10;  // Memory in / memory out
    localparam logic [7:0] REG_CTRL    = 8'h14;  // Bus path control

    // Field positions
    localparam int CMD_CODE_LSB  = 0;   // Command code, 3 bits
    localparam int CMD_DEV_LSB   = 8;   // Device number, 8 bits
    localparam int ST_BUSY_BIT   = 16;  // Status busy flag
    localparam int ST_PEND_BIT   = 17;  // Interrupt or data ready flag
    localparam int MC_OP_LSB     = 0;   // Memory operation kind, 2 bits
    localparam int MC_DEST_LSB   = 4;   // Destination module, 4 bits
    localparam int CT_OUTSEL_BIT = 0;   // 1: memory out reg drives I/O bus
    localparam int CT_OUTEN_BIT  = 1;   // Enables drive of I/O bus
    localparam int CT_INSEL_BIT  = 2;   // 1: I/O bus loads direct in reg
    localparam int CT_HSPEED_BIT = 3;   // High-speed channel mode

    // Reset values
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [7:0]  DEV_RST  = 8'h00;
    localparam logic [2:0]  CMD_RST  = 3'h0;
    localparam logic [3:0]  MOD_RST  = 4'h0;

    // Step added to the memory in register on a reference entry store
    localparam logic [15:0] DRT_STEP = 16'h0002;

    // Memory operation kinds requested by software
    localparam logic [1:0] OPK_READ    = 2'h0;
    localparam logic [1:0] OPK_WRITE   = 2'h1;
    localparam logic [1:0] OPK_STORE   = 2'h2;
    localparam logic [1:0] OPK_RESTORE = 2'h3;

    // Operation codes sent on the central memory bus
    localparam logic [1:0] MOP_READ  = 2'h1;
    localparam logic [1:0] MOP_WRITE = 2'h2;
    localparam logic [1:0] MOP_DATA  = 2'h3;

    // Memory sequencer states, Gray along idle-low-high-wait
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW  = 2'b01,
        M_HIGH = 2'b11,
        M_WAIT = 2'b10
    } iopb_mstate_e;

    // Word sent onto the central memory bus
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [3:0]  srcMod;
        logic [3:0]  dstMod;
        logic [1:0]  op;
    } iopb_cmb_s;

    // Word returned from memory
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [3:0]  srcMod;
        logic [3:0]  dstMod;
    } iopb_ret_s;

endpackage

// File: src/iopb_bridge.sv
// I/O processor bus bridge: direct commands, interrupt poll, memory path
`timescale 1ns/1ps
module iopb_bridge
    import iopb_pkg::*;
#(
    parameter logic [3:0] OWN_MODULE = 4'h1  // This unit's module number
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic [2:0]       ioCommandCode,
    output logic [7:0]       targetDeviceNumber,
    output logic             commandAcceptStrobe,
    input  wire logic        commandAckHandshake,
    input  wire logic        irqFromController,
    output logic             priorityPollChain,
    input  wire logic        pollGrantReply,
    input  wire logic [7:0]  pollDeviceNumber,
    output logic             cpuIrqOut,
    output logic [15:0]      ioBusDataOut,
    output logic             ioBusDataOutEn,
    input  wire logic [15:0] ioBusDataIn,
    input  wire logic        ioBusDataValid,
    input  wire logic        cpuLowBusRequest,
    input  wire logic        cpuHighBusRequest,
    input  wire logic        destModuleReady,
    output logic             ioSideBusClaim,
    output logic             cpuSelect,
    output iopb_cmb_s        cmbOut,
    input  wire iopb_ret_s   cmbRet,
    output logic             returnDataLatchStrobe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0]   cmdCode_r;      // Command code register
    logic [7:0]   target_device_number_r;        // Device number register
    logic         strobe_r;       // Accept strobe
    logic         poll_r;         // Poll chain drive
    logic         irq_r;          // Processor interrupt
    logic [7:0]   irqDev_r;       // Interrupting device latch
    logic [15:0]  memOut_r;       // Data returned from memory
    logic [15:0]  directOut_r;    // Direct data from processor
    logic [15:0]  memIn_r;        // Data bound for memory
    logic [15:0]  directIn_r;     // Direct in / memory address
    logic [3:0]   ctrl_r;         // Path control bits
    logic [1:0]   opKind_r;       // Requested memory operation
    logic [3:0]   destMod_r;      // Stored destination module
    logic         dataReady_r;    // Returned data ready flag
    iopb_mstate_e mState_r;       // Memory sequencer state
    logic         ioLowSel_r;     // Device low select flop
    logic         ioHighSel_r;    // Device high select flop
    logic         cpuSel_r;       // Processor select flop
    logic         claim_r;        // Registered bus claim
    iopb_cmb_s    cmb_r;          // Word on central memory bus
    logic         retStb_r;       // Return strobe pulse
    logic [15:0]  busOut_r;       // I/O bus drive data
    logic         busOutEn_r;     // I/O bus drive enable
    logic [31:0]  rdat_r;         // Wishbone read data
    logic         ack_r;          // Wishbone acknowledge
    logic         wbReq;          // New bus access this cycle
    logic         wbWr;           // Write access this cycle
    logic         ioLowReq;       // Device low request
    logic         ioHighReq;      // Device high request
    logic         ioClaim;        // Device about to set a select
    logic         retMatch;       // Both module comparisons match
    logic         memBusy;        // Memory sequence in flight

    // Byte-lane merge of a 16-bit register from a Wishbone write
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sl);
        logic [15:0] r;
        r = old;
        if (sl[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sl[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and arbitration terms
    assign wbReq   = cyc_i && stb_i && !ack_r;
    assign wbWr    = wbReq && we_i;
    assign memBusy = (mState_r != M_IDLE);
    // Device requests come from the sequencer
    assign ioLowReq  = (mState_r == M_LOW);
    assign ioHighReq = (mState_r == M_HIGH);
    // High always claims; low needs ready module and no CPU high
    assign ioClaim = ioHighReq ||
                     (ioLowReq && destModuleReady
                      && !cpuHighBusRequest);
    // Return must come from the addressed module and be for us
    assign retMatch = cmbRet.valid && (cmbRet.srcMod == destMod_r)
                      && (cmbRet.dstMod == OWN_MODULE);

    ////////////////////////////////////////////////////////////////////////
    // Wishbone acknowledge: one cycle after request, one cycle long
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wbReq;
        end
    end

    // Wishbone read data, unmapped reads as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_r <= 32'h0000_0000;
        end else if (wbReq && !we_i) begin
            case (adr_i)
                REG_CMD: begin
                    rdat_r <= {15'h0000, strobe_r, target_device_number_r,
                               5'h00, cmdCode_r};
                end
                REG_DIRECT: begin
                    rdat_r <= {16'h0000, directIn_r};
                end
                REG_IRQDEV: begin
                    rdat_r <= {14'h0000, irq_r, poll_r,
                               8'h00, irqDev_r};
                end
                REG_MEMCTL: begin
                    rdat_r <= {14'h0000, dataReady_r, memBusy,
                               8'h00, destMod_r, 2'h0, opKind_r};
                end
                REG_MEMDATA: begin
                    rdat_r <= {16'h0000, memOut_r};
                end
                REG_CTRL: begin
                    rdat_r <= {28'h000_0000, ctrl_r};
                end
                default: begin
                    rdat_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct command: launch on write, hold until acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmdCode_r <= CMD_RST;
            target_device_number_r   <= DEV_RST;
            strobe_r  <= 1'b0;
        end else if (strobe_r) begin
            if (commandAckHandshake) begin
                strobe_r <= 1'b0;
            end
        end else if (wbWr && adr_i == REG_CMD && sel_i[1:0] == 2'b11) begin
            cmdCode_r <= dat_i[CMD_CODE_LSB +: 3];
            target_device_number_r   <= dat_i[CMD_DEV_LSB +: 8];
            strobe_r  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt poll, device latch and processor interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            poll_r   <= 1'b0;
            irq_r    <= 1'b0;
            irqDev_r <= DEV_RST;
        end else begin
            if (poll_r && pollGrantReply) begin
                // Reply ends poll, number caught, interrupt raised
                poll_r   <= 1'b0;
                irqDev_r <= pollDeviceNumber;
                irq_r    <= 1'b1;
            end else begin
                if (irqFromController && !irq_r && !poll_r) begin
                    poll_r <= 1'b1;
                end
                // Processor clears after taking the number
                if (wbWr && adr_i == REG_IRQDEV) begin
                    irq_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Path control register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= 4'h0;
        end else if (wbWr && adr_i == REG_CTRL && sel_i[0]) begin
            ctrl_r <= dat_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direct out register from processor writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            directOut_r <= DATA_RST;
        end else if (wbWr && adr_i == REG_DIRECT) begin
            directOut_r <= merge16(directOut_r, dat_i, sel_i);
        end
    end

    // Direct in register loaded from the I/O bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            directIn_r <= DATA_RST;
        end else if (ioBusDataValid && ctrl_r[CT_INSEL_BIT]) begin
            directIn_r <= ioBusDataIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory in register: I/O bus, software, restore or store step
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memIn_r <= DATA_RST;
        end else if (wbWr && adr_i == REG_MEMCTL && !memBusy
                     && !ctrl_r[CT_HSPEED_BIT]) begin
            if (dat_i[MC_OP_LSB +: 2] == OPK_RESTORE) begin
                memIn_r <= memOut_r;
            end else if (dat_i[MC_OP_LSB +: 2] == OPK_STORE) begin
                memIn_r <= memIn_r + DRT_STEP;
            end
        end else if (wbWr && adr_i == REG_MEMDATA) begin
            memIn_r <= merge16(memIn_r, dat_i, sel_i);
        end else if (ioBusDataValid && !ctrl_r[CT_INSEL_BIT]) begin
            memIn_r <= ioBusDataIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory sequencer: address phase low, data phase high, wait return
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mState_r  <= M_IDLE;
            opKind_r  <= OPK_READ;
            destMod_r <= MOD_RST;
        end else begin
            case (mState_r)
                M_IDLE: begin
                    // High-speed mode leaves memory to the channel
                    if (wbWr && adr_i == REG_MEMCTL
                        && !ctrl_r[CT_HSPEED_BIT]) begin
                        opKind_r  <= dat_i[MC_OP_LSB +: 2];
                        destMod_r <= dat_i[MC_DEST_LSB +: 4];
                        mState_r  <= M_LOW;
                    end
                end
                M_LOW: begin
                    if (ioClaim) begin
                        mState_r <= (opKind_r == OPK_READ) ? M_WAIT : M_HIGH;
                    end
                end
                M_HIGH: begin
                    mState_r <= M_IDLE;
                end
                M_WAIT: begin
                    if (retMatch) begin
                        mState_r <= M_IDLE;
                    end
                end
                default: begin
                    mState_r <= M_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select flops and claim; device beats CPU unless CPU high vs low or low without a ready module
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ioLowSel_r  <= 1'b0;
            ioHighSel_r <= 1'b0;
            cpuSel_r    <= 1'b0;
            claim_r     <= 1'b0;
        end else begin
            claim_r     <= ioClaim;
            ioLowSel_r  <= ioClaim && ioLowReq;
            ioHighSel_r <= ioClaim && ioHighReq;
            cpuSel_r    <= (cpuLowBusRequest || cpuHighBusRequest)
                           && !ioClaim;
        end
    end

    // Word placed on the central memory bus by a select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmb_r <= '0;
        end else begin
            cmb_r.valid  <= ioClaim;
            cmb_r.srcMod <= OWN_MODULE;
            cmb_r.dstMod <= destMod_r;
            if (ioLowReq) begin
                // Reads address memory from the direct in register
                cmb_r.data <= (opKind_r == OPK_READ) ? directIn_r
                                                     : memIn_r;
                cmb_r.op   <= (opKind_r == OPK_READ) ? MOP_READ
                                                     : MOP_WRITE;
            end else begin
                cmb_r.data <= memIn_r;
                cmb_r.op   <= MOP_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory return: match locks memory out register and flags ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memOut_r    <= DATA_RST;
            retStb_r    <= 1'b0;
            dataReady_r <= 1'b0;
        end else begin
            retStb_r <= retMatch && mState_r == M_WAIT;
            if (retMatch && mState_r == M_WAIT) begin
                memOut_r    <= cmbRet.data;
                dataReady_r <= 1'b1;
            end else if (wbWr && adr_i == REG_MEMCTL) begin
                dataReady_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O bus data drive from either output register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busOut_r   <= DATA_RST;
            busOutEn_r <= 1'b0;
        end else begin
            busOut_r   <= ctrl_r[CT_OUTSEL_BIT] ? memOut_r
                                                : directOut_r;
            busOutEn_r <= ctrl_r[CT_OUTEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output connections, all from flops
    assign dat_o                 = rdat_r;
    assign ack_o                 = ack_r;
    assign ioCommandCode         = cmdCode_r;
    assign targetDeviceNumber    = target_device_number_r;
    assign commandAcceptStrobe   = strobe_r;
    assign priorityPollChain     = poll_r;
    assign cpuIrqOut             = irq_r;
    assign ioBusDataOut          = busOut_r;
    assign ioBusDataOutEn        = busOutEn_r;
    assign ioSideBusClaim        = claim_r;
    assign cpuSelect             = cpuSel_r;
    assign cmbOut                = cmb_r;
    assign returnDataLatchStrobe = retStb_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_strobe_holds: assert property (
        strobe_r && !commandAckHandshake |=> strobe_r
            && $stable(cmdCode_r) && $stable(target_device_number_r))
        else $error("accept strobe or command changed before ack");
    a_strobe_drops: assert property (
        strobe_r && commandAckHandshake |=> !strobe_r)
        else $error("accept strobe not released after ack");
    a_reply_latches: assert property (
        poll_r && pollGrantReply |=> irqDev_r == $past(pollDeviceNumber)
            && irq_r && !poll_r)
        else $error("poll reply did not latch number and interrupt");
    a_poll_starts: assert property (
        irqFromController && !irq_r && !poll_r |=> poll_r)
        else $error("poll not started on controller request");
    a_cpu_high_wins: assert property (
        ioLowReq && cpuHighBusRequest |=> !ioLowSel_r && cpuSel_r)
        else $error("device low beat processor high request");
    a_claim_blocks: assert property (
        ioClaim |=> claim_r && !cpuSel_r)
        else $error("claim did not block processor select");
    a_low_needs_ready: assert property (
        ioLowSel_r |-> $past(destModuleReady))
        else $error("low select set without ready module");
    a_ret_strobe: assert property (
        retStb_r |-> memOut_r == $past(cmbRet.data)
            && $past(cmbRet.dstMod) == OWN_MODULE && dataReady_r)
        else $error("return strobe without matching return");
    a_store_step: assert property (
        mState_r == M_IDLE ##1 mState_r == M_LOW && opKind_r == OPK_STORE
            |-> memIn_r == $past(memIn_r) + DRT_STEP)
        else $error("reference store did not add two");
    a_low_drives: assert property (
        ioLowSel_r && opKind_r != OPK_READ |-> cmb_r.valid
            && cmb_r.data == $past(memIn_r) && cmb_r.op == MOP_WRITE)
        else $error("low select did not drive memory in word");

    c_command: cover property (strobe_r ##[1:8] !strobe_r);
    c_interrupt: cover property (poll_r ##[1:20] irq_r);
    c_mem_read: cover property (mState_r == M_WAIT ##[1:30] retStb_r);
    c_cpu_high: cover property (ioLowReq && cpuHighBusRequest);

endmodule

// File: dv/iopb_ctrl_model.sv
// Peripheral controller model on the shared I/O bus
`timescale 1ns/1ps
module iopb_ctrl_model (
    input  wire logic       clk,
    input  wire logic       strobe,
    input  wire logic       poll,
    input  wire logic [7:0] myDev,
    input  wire logic [3:0] lag,
    output logic            ackHs = 1'h0,
    output logic            grant = 1'h0,
    output logic [7:0]      grantDev = 8'h00
);
    int cnt = 0;  // Cycles the strobe has stood
    always @(posedge clk) begin  // Late acknowledge, one reply per poll
        cnt <= strobe ? cnt + 1 : 0;
        ackHs <= strobe && !ackHs && cnt >= lag;  // One-cycle answer
        grant <= poll && !grant;
        grantDev <= poll && !grant ? myDev : ~grantDev;
    end
endmodule

// File: dv/io_processor_bus_interface_bench.sv
// Self-checking bench for the I/O processor bus bridge
`timescale 1ns/1ps
module io_processor_bus_interface_bench;
    import iopb_pkg::*;
    logic clk = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [7:0] adr_i = '0, myDev = '0, targetDeviceNumber, pollDeviceNumber;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic [15:0] ioBusDataIn = '0, ioBusDataOut, w, d;
    logic [3:0] sel_i = 4'hF, lag = '0, dst;
    logic [2:0] ioCommandCode;
    logic commandAcceptStrobe, commandAckHandshake, pollGrantReply, cpuIrqOut;
    logic irqFromController = 0, priorityPollChain, ioBusDataOutEn, cpuSelect;
    logic ioBusDataValid = 0, cpuLowBusRequest = 0, cpuHighBusRequest = 0;
    logic destModuleReady = 0, ioSideBusClaim, returnDataLatchStrobe;
    iopb_cmb_s cmbOut;
    iopb_ret_s cmbRet = '0;
    int failCount = 0, comparisons = 0;
    logic [25:0] expQ[$];  // Words the memory bus should carry next
    iopb_bridge uut (.*);
    iopb_ctrl_model ctl (.clk(clk), .strobe(commandAcceptStrobe), .lag(lag),
        .poll(priorityPollChain), .myDev(myDev), .grant(pollGrantReply),
        .ackHs(commandAckHandshake), .grantDev(pollDeviceNumber));
    always #20 clk = ~clk;  // 25 MHz
    task automatic chk(input logic [31:0] s, e);
        comparisons++;
        if (s !== e) failCount++;
        if (s !== e) $display("BAD at %0t seen %h expected %h", $time, s, e);
    endtask
    task automatic wb(input logic wr, logic [7:0] a, logic [31:0] v);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, wr, a, v};
        do @(posedge clk); while (ack_o !== 1);
        rd = dat_o;  // Read data taken at the ack edge
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk);
    endtask
    always @(posedge clk) if (cmbOut.valid === 1)  // Claim rides with word
        chk({ioSideBusClaim, cmbOut[25:0]},
            expQ.size() ? {1'b1, expQ.pop_front()} : 'x);
    task automatic testDone(input int hung);
        failCount += hung;
        $display("compares %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial #80000 testDone(1);  // Hang guard, about 2000 cycles
    initial begin
        void'($urandom(92785));
        repeat (3) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 2; i++) begin  // Prompt, then slow controller
            w = 16'($urandom);
            lag <= 4'(i * 9);
            wb(1, REG_CMD, {16'h0000, w[7:0], 5'h00, w[10:8]});
            if (i) begin  // Busy read, then a refused second command
                wb(0, REG_CMD, 0);
                chk(rd, {15'h0000, 1'b1, w[7:0], 5'h00, w[10:8]});
                wb(1, REG_CMD, ~rd);
            end
            while (commandAckHandshake !== 1) @(posedge clk);
            chk({ioCommandCode, targetDeviceNumber}, w[10:0]);
            chk(commandAcceptStrobe, 1);
            @(posedge clk);
            chk(commandAcceptStrobe, 0);
        end
        $display("command test done");
        for (int op = 1; op < 4; op++) begin  // Write, store, restore
            {w, dst} = 20'($urandom);
            {ioBusDataValid, ioBusDataIn} <= {1'b1, w};
            @(posedge clk);
            ioBusDataValid <= 0;
            d = op == 3 ? DATA_RST : w + (op == 2 ? DRT_STEP : '0);
            expQ = '{{d, 4'h1, dst, MOP_WRITE}, {d, 4'h1, dst, MOP_DATA}};
            {destModuleReady, cpuHighBusRequest} <= {op[0], op[0]};
            wb(1, REG_MEMCTL, {24'h00_0000, dst, 2'h0, 2'(op)});
            repeat (4) @(posedge clk);
            chk(expQ.size(), 2);
            chk(cpuSelect, op[0]);
            {destModuleReady, cpuHighBusRequest} <= 2'b10;
            while (expQ.size() > 0) @(posedge clk);
        end
        $display("memory test done");
        dst = 4'($urandom);  // Read: address word, then the return
        d = 16'($urandom);
        expQ = '{{DATA_RST, 4'h1, dst, MOP_READ}};
        wb(1, REG_MEMCTL, {24'h00_0000, dst, 4'h0});
        cmbRet <= {1'b1, d, ~dst, 4'h1};  // Foreign source is ignored
        @(posedge clk);
        cmbRet <= {1'b1, d, dst, 4'h1};
        @(posedge clk);
        cmbRet <= '0;
        chk(returnDataLatchStrobe, 0);
        @(posedge clk);
        chk(returnDataLatchStrobe, 1);
        wb(0, REG_MEMDATA, 0);
        chk(rd, {16'h0000, d});
        wb(0, REG_MEMCTL, 0);
        chk(rd[17:16], 2'b10);
        $display("return test done");
        myDev <= 8'($urandom);
        irqFromController <= 1;
        while (cpuIrqOut !== 1) @(posedge clk);
        irqFromController <= 0;
        chk(priorityPollChain, 0);
        wb(0, REG_IRQDEV, 0);
        chk(rd, {14'h0000, 2'b10, 8'h00, myDev});
        wb(1, REG_IRQDEV, 0);
        chk(cpuIrqOut, 0);
        $display("interrupt test done");
        w = 16'($urandom);
        wb(1, REG_DIRECT, {16'h0000, w});
        wb(1, REG_CTRL, 32'h0000_0006);  // Drive direct out, load direct in
        chk({ioBusDataOutEn, ioBusDataOut}, {1'b1, w});
        {ioBusDataValid, ioBusDataIn} <= {1'b1, ~w};
        @(posedge clk);
        ioBusDataValid <= 0;
        wb(0, REG_DIRECT, 0);
        chk(rd, {16'h0000, ~w});
        wb(1, REG_CTRL, 32'h0000_000B);  // Memory out drives, high speed
        chk({ioBusDataOutEn, ioBusDataOut}, {1'b1, d});
        wb(1, REG_MEMCTL, 32'h0000_0011);  // Refused in high-speed mode
        wb(0, REG_MEMCTL, 0);
        chk(rd[17:16], 2'b00);
        $display("path test done");
        testDone(0);
    end
endmodule
